// >>> rtl/pic_pkg.sv
// package: pin interface control constants, pin field positions and carrier types
package pic_pkg;
  localparam int ADDR_W          = 32;
  localparam int DATA_W          = 32;
  localparam int NARROW_ADDR_W   = 26;
  localparam logic [31:0] NARROW_ADDR_MASK = 32'h03FFFFFF;

  // positions of the control pins inside the synchronised pin vector
  localparam int PIN_MCLK        = 0;
  localparam int PIN_STALL_N     = 1;
  localparam int PIN_CP_BUSY     = 2;
  localparam int PIN_CP_ABSENT   = 3;
  localparam int PIN_WIDE_SEL    = 4;
  localparam int PIN_DBUS_EN     = 5;
  localparam int PIN_DBG_EN      = 6;
  localparam int PIN_DBG_REQ     = 7;
  localparam int PIN_DEBUG_CLOCK        = 8;
  localparam int PIN_EXT0        = 9;
  localparam int PIN_EXT1        = 10;
  localparam int PIN_IRQ_N       = 11;
  localparam int PIN_FIQ_N       = 12;
  localparam int PIN_IRQ_ALREADY_SYNC       = 13;
  localparam int PIN_ALE         = 14;
  localparam int PIN_ABE         = 15;
  localparam int CTL_PINS        = 16;
  localparam int SYNC_W          = CTL_PINS + DATA_W;

  // reset value of the pin vector: active-low requests idle high, bus and address enables high, debug enable low
  localparam logic [CTL_PINS-1:0] CTL_PIN_RST = 16'hD832;
  localparam logic [SYNC_W-1:0]   SYNC_RST    = {32'h00000000, CTL_PIN_RST};

  typedef struct packed {
    logic              xfer_valid;
    logic              write;
    logic              swap;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              cp_valid;
    logic              instr_done;
    logic              debug_exit;
  } pic_core_req_t;

  typedef struct packed {
    logic              xfer_busy;
    logic              xfer_done;
    logic [DATA_W-1:0] rdata;
    logic              cp_busy;
    logic              cp_done;
    logic              cp_undef;
    logic              halt_req;
  } pic_core_rsp_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT_P1, BUS_XFER} pic_bus_state_t;
  typedef enum logic [1:0] {CP_IDLE, CP_WAIT_P1, CP_ASSERT, CP_BUSY_WAIT} pic_cp_state_t;
endpackage

// >>> rtl/pic_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module pic_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         core_clk_in,
  input  wire logic         srst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // the first stage feeds only the second stage
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule // pic_sync
`default_nettype wire

// >>> rtl/pic_top.sv
// processor pin interface control: clock phases, data bus, lock, coprocessor, debug pins
// Overview of operation
// - sample coproc_busy at end of phase one
// - data bus driven only on writes
// - write data valid phase one through two
// - wide select picks 32 or 26-bit data addresses
// - core_data_bus_en low floats the data bus
// - debug_ack high exactly in debug state
// - debug_enable_in low disables debug features
// - debug_request enters debug after current instruction
// - exported_clock follows main or debug clock
// - ext_cond inputs exported as breakpoint qualifiers
// - float flag while high-z instruction loaded
// - irq_already_sync bypasses interrupt synchronisers
// - lock high marks locked access
// - lock changes while main_clock high, swap only
// - lock latched by addr_latch_en, floats without addr_drive_en
// - phase one clock low, phase two high with stall_n
// - tolerate stretched clock or stall_n low
// - coproc_instr_n low waits for coprocessor answer
// - absent at phase one end gives undefined trap
`timescale 1ns/10ps
`default_nettype none
module pic_top (
  input  wire logic                  core_clk_in,
  input  wire logic                  srst_in,
  // pins from the memory system, coprocessor and debug hardware
  input  wire logic                  main_clock_in,
  input  wire logic                  stall_n_in,
  input  wire logic                  coproc_busy_in,
  input  wire logic                  coproc_absent_in,
  input  wire logic                  wide_data_space_sel_in,
  input  wire logic                  core_data_bus_en_in,
  input  wire logic                  debug_enable_in,
  input  wire logic                  debug_request_in,
  input  wire logic                  debug_clock_in,
  input  wire logic                  ext_cond_0_in,
  input  wire logic                  ext_cond_1_in,
  input  wire logic                  irq_req_n_in,
  input  wire logic                  fast_irq_req_n_in,
  input  wire logic                  irq_already_sync_in,
  input  wire logic                  addr_latch_en_in,
  input  wire logic                  addr_drive_en_in,
  input  wire logic [pic_pkg::DATA_W-1:0] data_in,
  // core side, same clock domain
  input  wire pic_pkg::pic_core_req_t core_req_in,
  input  wire logic                  tap_float_outputs_flag_loaded_in,
  output var pic_pkg::pic_core_rsp_t core_rsp_out,
  // pins toward the outside
  output logic [pic_pkg::DATA_W-1:0] data_out,
  output logic                       data_oe_out,
  output logic [pic_pkg::ADDR_W-1:0] addr_out,
  output logic                       addr_oe_out,
  output logic                       write_not_read_out,
  output logic                       write_not_read_oe_out,
  output logic                       lock_out,
  output logic                       lock_oe_out,
  output logic                       coproc_instr_n_out,
  output logic                       debug_ack_out,
  output logic                       exported_clock_out,
  output logic [1:0]                 ext_cond_out,
  output logic                       float_outputs_flag_out,
  output logic                       irq_req_n_out,
  output logic                       fast_irq_req_n_out
);
  import pic_pkg::*;

  logic [SYNC_W-1:0] pins_s;
  logic              mclk_s, stall_s, mclk_q, stall_q;
  logic              next_mclk_q, next_stall_q;
  logic              cycle_end, phase1_end, dbg_en;

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  pic_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .async_in    ({data_in, addr_drive_en_in, addr_latch_en_in, irq_already_sync_in,
                   fast_irq_req_n_in, irq_req_n_in, ext_cond_1_in, ext_cond_0_in,
                   debug_clock_in, debug_request_in, debug_enable_in, core_data_bus_en_in,
                   wide_data_space_sel_in, coproc_absent_in, coproc_busy_in, stall_n_in,
                   main_clock_in}),
    .sync_out    (pins_s)
  );

  // phase tracking: phase two only counts while stall_n is high, so a held
  // stall stretches the cycle whatever main_clock does
  always_comb begin
    mclk_s       = pins_s[PIN_MCLK];
    stall_s      = pins_s[PIN_STALL_N];
    dbg_en       = pins_s[PIN_DBG_EN];
    next_mclk_q  = mclk_s;
    next_stall_q = mclk_s ? stall_s : stall_q;
    phase1_end   = rose(mclk_s, mclk_q);
    cycle_end    = rose(mclk_q, mclk_s) & stall_q;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mclk_q  <= 1'b0;
      stall_q <= 1'b1;
    end else begin
      mclk_q  <= next_mclk_q;
      stall_q <= next_stall_q;
    end
  end

  // data transfer sequencing
  pic_bus_state_t    bus_st, next_bus_st;
  logic              cur_write, next_cur_write;
  logic [DATA_W-1:0] next_data_out, next_rdata;
  logic              next_data_oe, next_wnr, next_xfer_done;

  always_comb begin
    next_bus_st    = bus_st;
    next_cur_write = cur_write;
    next_data_out  = data_out;
    next_wnr       = write_not_read_out;
    next_rdata     = core_rsp_out.rdata;
    next_xfer_done = 1'b0;
    case (bus_st)
      BUS_IDLE: begin
        if (core_req_in.xfer_valid) begin
          next_cur_write = core_req_in.write;
          next_data_out  = core_req_in.wdata;
          next_bus_st    = BUS_WAIT_P1;
        end
      end
      BUS_WAIT_P1: begin
        if (cycle_end) begin
          next_wnr    = cur_write;
          next_bus_st = BUS_XFER;
        end
      end
      default: begin
        // read data is taken only when a real phase two ends
        if (cycle_end) begin
          if (!cur_write) begin
            next_rdata = pins_s[SYNC_W-1:CTL_PINS];
          end
          next_wnr       = 1'b0;
          next_xfer_done = 1'b1;
          next_bus_st    = BUS_IDLE;
        end
      end
    endcase
    // write data driven from phase one start through the end of phase two
    next_data_oe = (next_bus_st == BUS_XFER) & next_cur_write
                   & pins_s[PIN_DBUS_EN];
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      bus_st             <= BUS_IDLE;
      cur_write          <= 1'b0;
      data_out           <= 32'h00000000;
      data_oe_out        <= 1'b0;
      write_not_read_out <= 1'b0;
      core_rsp_out.rdata <= 32'h00000000;
      core_rsp_out.xfer_done <= 1'b0;
      core_rsp_out.xfer_busy <= 1'b0;
    end else begin
      bus_st             <= next_bus_st;
      cur_write          <= next_cur_write;
      data_out           <= next_data_out;
      data_oe_out        <= next_data_oe;
      write_not_read_out <= next_wnr;
      core_rsp_out.rdata <= next_rdata;
      core_rsp_out.xfer_done <= next_xfer_done;
      core_rsp_out.xfer_busy <= (next_bus_st != BUS_IDLE);
    end
  end

  // address and lock outputs behave as the pads' transparent latches
  logic [ADDR_W-1:0] addr_hold, next_addr_hold, next_addr;
  logic              next_lock, next_lock_out;

  always_comb begin
    next_addr_hold = addr_hold;
    if (bus_st == BUS_IDLE && core_req_in.xfer_valid) begin
      next_addr_hold = pins_s[PIN_WIDE_SEL] ? core_req_in.addr
                       : (core_req_in.addr & NARROW_ADDR_MASK);
    end
    // lock only moves while main_clock is high, so it never changes mid phase one
    next_lock = lock_out;
    if (mclk_s) begin
      next_lock = core_req_in.swap;
    end
    next_addr     = addr_out;
    next_lock_out = lock_out;
    if (pins_s[PIN_ALE]) begin
      next_addr     = next_addr_hold;
      next_lock_out = next_lock;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      addr_hold             <= 32'h00000000;
      addr_out              <= 32'h00000000;
      addr_oe_out           <= 1'b0;
      lock_out              <= 1'b0;
      lock_oe_out           <= 1'b0;
      write_not_read_oe_out <= 1'b0;
    end else begin
      addr_hold             <= next_addr_hold;
      addr_out              <= next_addr;
      addr_oe_out           <= pins_s[PIN_ABE];
      lock_out              <= next_lock_out;
      lock_oe_out           <= pins_s[PIN_ABE];
      write_not_read_oe_out <= pins_s[PIN_ABE];
    end
  end

  // coprocessor handshake
  pic_cp_state_t cp_st, next_cp_st;
  logic          next_cpi_n, next_cp_done, next_cp_undef;

  always_comb begin
    next_cp_st    = cp_st;
    next_cpi_n    = coproc_instr_n_out;
    next_cp_done  = 1'b0;
    next_cp_undef = 1'b0;
    case (cp_st)
      CP_IDLE: begin
        if (core_req_in.cp_valid) begin
          next_cp_st = CP_WAIT_P1;
        end
      end
      CP_WAIT_P1: begin
        if (cycle_end) begin
          next_cpi_n = 1'b0;
          next_cp_st = CP_ASSERT;
        end
      end
      CP_ASSERT: begin
        if (phase1_end) begin
          if (pins_s[PIN_CP_ABSENT]) begin
            next_cpi_n    = 1'b1;
            next_cp_undef = 1'b1;
            next_cp_st    = CP_IDLE;
          end else if (!pins_s[PIN_CP_BUSY]) begin
            next_cpi_n   = 1'b1;
            next_cp_done = 1'b1;
            next_cp_st   = CP_IDLE;
          end else begin
            next_cp_st = CP_BUSY_WAIT;
          end
        end
      end
      default: begin
        // busy is looked at once per cycle, at the end of each phase one
        if (phase1_end && !pins_s[PIN_CP_BUSY]) begin
          next_cpi_n   = 1'b1;
          next_cp_done = 1'b1;
          next_cp_st   = CP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cp_st                 <= CP_IDLE;
      coproc_instr_n_out    <= 1'b1;
      core_rsp_out.cp_done  <= 1'b0;
      core_rsp_out.cp_undef <= 1'b0;
      core_rsp_out.cp_busy  <= 1'b0;
    end else begin
      cp_st                 <= next_cp_st;
      coproc_instr_n_out    <= next_cpi_n;
      core_rsp_out.cp_done  <= next_cp_done;
      core_rsp_out.cp_undef <= next_cp_undef;
      core_rsp_out.cp_busy  <= (next_cp_st != CP_IDLE);
    end
  end

  // debug state, exported clock and qualifiers
  logic       dbg_state, next_dbg_state, next_halt;
  logic       next_exported_clock, next_irq_n, next_fiq_n;
  logic [1:0] next_ext;

  always_comb begin
    next_dbg_state = dbg_state;
    // a held request is honoured at the next instruction boundary
    if (!dbg_en) begin
      next_dbg_state = 1'b0;
    end else if (dbg_state && core_req_in.debug_exit) begin
      next_dbg_state = 1'b0;
    end else if (pins_s[PIN_DBG_REQ] && core_req_in.instr_done) begin
      next_dbg_state = 1'b1;
    end
    next_halt = dbg_en & pins_s[PIN_DBG_REQ];
    next_exported_clock = next_dbg_state ? pins_s[PIN_DEBUG_CLOCK] : (mclk_s & stall_s);
    next_ext  = dbg_en ? {pins_s[PIN_EXT1], pins_s[PIN_EXT0]} : 2'h0;
    // when the pins are already synchronous the raw level is registered once;
    // the two-flop path costs two core cycles of interrupt latency
    if (pins_s[PIN_IRQ_ALREADY_SYNC]) begin
      next_irq_n = irq_req_n_in;
      next_fiq_n = fast_irq_req_n_in;
    end else begin
      next_irq_n = pins_s[PIN_IRQ_N];
      next_fiq_n = pins_s[PIN_FIQ_N];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      dbg_state              <= 1'b0;
      debug_ack_out          <= 1'b0;
      core_rsp_out.halt_req  <= 1'b0;
      exported_clock_out     <= 1'b0;
      ext_cond_out           <= 2'h0;
      float_outputs_flag_out <= 1'b0;
      irq_req_n_out          <= 1'b1;
      fast_irq_req_n_out     <= 1'b1;
    end else begin
      dbg_state              <= next_dbg_state;
      debug_ack_out          <= next_dbg_state;
      core_rsp_out.halt_req  <= next_halt;
      exported_clock_out     <= next_exported_clock;
      ext_cond_out           <= next_ext;
      float_outputs_flag_out <= tap_float_outputs_flag_loaded_in;
      irq_req_n_out          <= next_irq_n;
      fast_irq_req_n_out     <= next_fiq_n;
    end
  end
endmodule // pic_top
`default_nettype wire

// >>> tb/pic_asserts.sv
// checker on the pin interface control outputs, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module pic_asserts (
  input wire logic                   core_clk_in,
  input wire logic                   srst_in,
  input wire logic                   main_clock_in,
  input wire logic                   stall_n_in,
  input wire logic                   wide_data_space_sel_in,
  input wire logic                   core_data_bus_en_in,
  input wire logic                   debug_enable_in,
  input wire logic                   addr_latch_en_in,
  input wire logic                   addr_drive_en_in,
  input wire logic                   tap_float_outputs_flag_loaded_in,
  input wire pic_pkg::pic_core_req_t core_req_in,
  input wire pic_pkg::pic_core_rsp_t core_rsp_out,
  input wire logic [31:0]            data_out,
  input wire logic                   data_oe_out,
  input wire logic [31:0]            addr_out,
  input wire logic                   addr_oe_out,
  input wire logic                   write_not_read_out,
  input wire logic                   lock_out,
  input wire logic                   lock_oe_out,
  input wire logic                   coproc_instr_n_out,
  input wire logic                   debug_ack_out,
  input wire logic                   exported_clock_out,
  input wire logic [1:0]             ext_cond_out,
  input wire logic                   float_outputs_flag_out
);
  import pic_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // age keeps $past from looking back into reset
  logic [2:0] age;
  logic [2:0] next_age;
  wire        take = core_req_in.xfer_valid && !core_rsp_out.xfer_busy;
  always_comb next_age = srst_in ? 3'h0 : age + {2'h0, !age[2]};
  always_ff @(posedge core_clk_in) age <= next_age;

  chk_oe_on_write: assert property (data_oe_out |-> write_not_read_out)
    else $error("data driven outside a write cycle");
  chk_dbe_float: assert property (!core_data_bus_en_in [*4] |=> !data_oe_out)
    else $error("data driven with bus enable low");
  chk_wdata_hold: assert property (data_oe_out && $past(data_oe_out) |-> $stable(data_out))
    else $error("write word changed while driven");
  chk_dbg_off: assert property (!debug_enable_in [*4] |=> !debug_ack_out &&
    ext_cond_out == 2'h0 && !core_rsp_out.halt_req)
    else $error("debug active while disabled");
  chk_narrow_addr: assert property ((!wide_data_space_sel_in && addr_latch_en_in) [*4]
    ##1 take |=> ##1 addr_out == ($past(core_req_in.addr, 2) & NARROW_ADDR_MASK))
    else $error("narrow address not masked");
  chk_abe_float: assert property (!addr_drive_en_in [*4] |=> !addr_oe_out && !lock_oe_out)
    else $error("address or lock driven with drive enable low");
  chk_float_outputs_flag_flag: assert property (tap_float_outputs_flag_loaded_in |=> float_outputs_flag_out)
    else $error("float flag missing");
  chk_lock_swap: assert property ((!core_req_in.swap && addr_latch_en_in) [*8] |=> !lock_out)
    else $error("lock high without swap");
  chk_exported_clock_mclk: assert property (age[2] && !debug_ack_out && !$past(debug_ack_out) |->
    exported_clock_out == ($past(main_clock_in, 3) && $past(stall_n_in, 3)))
    else $error("exported clock does not follow memory clock");
  chk_cp_answer: assert property (core_rsp_out.cp_done || core_rsp_out.cp_undef |->
    coproc_instr_n_out && $past(coproc_instr_n_out) == 1'b0)
    else $error("coprocessor answer without select");
endmodule // pic_asserts

bind pic_top pic_asserts i_chk (.*);
`default_nettype wire

// >>> tb/pic_far_model.sv
// far-side model: memory clock, stall, read word and coprocessor answers
`timescale 1ns/10ps
`default_nettype none
module pic_far_model (
  input  wire logic        core_clk_in,
  input  wire logic        slow_in,
  input  wire logic        cp_absent_in,
  input  wire logic        cp_slow_in,
  input  wire logic [31:0] rd_word_in,
  input  wire logic        write_not_read_in,
  input  wire logic        coproc_instr_n_in,
  output logic             main_clock_out,
  output logic             stall_n_out,
  output logic             coproc_busy_out,
  output logic             coproc_absent_out,
  output logic [31:0]      data_out
);
  logic [1:0]  ph = 2'h0;
  logic [4:0]  cp_cnt = 5'h00;
  logic [31:0] last = 32'h00000000;
  initial main_clock_out = 1'b0;
  initial stall_n_out = 1'b1;
  always @(posedge core_clk_in) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    if (ph == 2'h2) begin
      main_clock_out <= !main_clock_out;
      // stall chosen as phase one starts, held over the following phase two
      if (main_clock_out) stall_n_out <= slow_in ? !stall_n_out : 1'b1;
    end
    cp_cnt <= coproc_instr_n_in ? 5'h00 : cp_cnt + {4'h0, cp_cnt != 5'h1F};
    if (!write_not_read_in) last <= rd_word_in;
  end
  assign coproc_absent_out = !coproc_instr_n_in && cp_absent_in;
  assign coproc_busy_out = !coproc_instr_n_in && cp_slow_in && cp_cnt < 5'h18;
  // released bus shows the inverse so a stale word never passes
  assign data_out = write_not_read_in ? ~last : rd_word_in;
endmodule // pic_far_model
`default_nettype wire

// >>> tb/pic_top_test.sv
// self-checking bench for the pin interface control block
`timescale 1ns/10ps
`default_nettype none
module pic_top_test;
  import pic_pkg::*;
  typedef struct packed {
    logic        w;
    logic        wide;
    logic        slow;
    logic [31:0] a;
    logic [31:0] d;
  } pic_row_t;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic main_clock_in, stall_n_in, coproc_busy_in, coproc_absent_in;
  logic wide_data_space_sel_in = 1'b1, core_data_bus_en_in = 1'b1, debug_enable_in = 1'b0;
  logic debug_request_in = 1'b0, debug_clock_in = 1'b0, ext_cond_0_in = 1'b0;
  logic ext_cond_1_in = 1'b0, irq_req_n_in = 1'b1, fast_irq_req_n_in = 1'b1;
  logic irq_already_sync_in = 1'b0, addr_latch_en_in = 1'b1, addr_drive_en_in = 1'b1;
  logic tap_float_outputs_flag_loaded_in = 1'b0, slow = 1'b0, cp_abs = 1'b0, cp_slow = 1'b0;
  pic_core_req_t core_req_in = '0;
  pic_core_rsp_t core_rsp_out;
  logic [31:0] data_out, bus, far_data, addr_out, rd, wd, ad;
  logic [31:0] rd_word = 32'h00000000;
  logic data_oe_out, addr_oe_out, write_not_read_out, write_not_read_oe_out, lock_out;
  logic lock_oe_out, coproc_instr_n_out, debug_ack_out, exported_clock_out, oe, rw;
  logic float_outputs_flag_out, irq_req_n_out, fast_irq_req_n_out;
  logic [1:0] ext_cond_out;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  pic_row_t rows [5] = '{
    '{1'b1, 1'b1, 1'b0, 32'hFC000010, 32'hA5A50F0F},
    '{1'b0, 1'b1, 1'b0, 32'h80000004, 32'h12345678},
    '{1'b0, 1'b0, 1'b0, 32'hFFFFFFF0, 32'hC3C3E1E1},
    '{1'b1, 1'b0, 1'b1, 32'h4C000008, 32'h0F0F5AA5},
    '{1'b0, 1'b1, 1'b1, 32'h7FFFFFFC, 32'h9ABCDEF0}};

  assign bus = data_oe_out ? data_out : far_data;
  pic_top i_dut (.*, .data_in(bus));
  pic_far_model i_far (.core_clk_in(core_clk_in), .slow_in(slow), .cp_absent_in(cp_abs),
    .cp_slow_in(cp_slow), .rd_word_in(rd_word), .write_not_read_in(write_not_read_out),
    .coproc_instr_n_in(coproc_instr_n_out), .main_clock_out(main_clock_in),
    .stall_n_out(stall_n_in), .coproc_busy_out(coproc_busy_in),
    .coproc_absent_out(coproc_absent_in), .data_out(far_data));

  always #20 core_clk_in = ~core_clk_in;

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk_in);
    @(posedge core_clk_in);
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    oe = 1'b0;
    rw = 1'b0;
    wd = ~d;
    core_req_in.xfer_valid <= 1'b1;
    core_req_in.write <= w;
    core_req_in.addr <= a;
    core_req_in.wdata <= d;
    @(posedge core_clk_in);
    core_req_in.xfer_valid <= 1'b0;
    do begin
      @(negedge core_clk_in);
      n++;
      if (data_oe_out) oe = 1'b1;
      if (data_oe_out) wd = data_out;
      if (write_not_read_out) rw = 1'b1;
      if (core_rsp_out.xfer_busy) ad = addr_out;
    end while (core_rsp_out.xfer_done !== 1'b1 && n < 300);
    chk("transfer done", {31'h0, core_rsp_out.xfer_done}, 32'h1);
    rd = core_rsp_out.rdata;
    @(posedge core_clk_in);
  endtask

  task automatic cp(input logic ab, input logic sl);
    int n;
    logic lo;
    logic bz;
    n = 0;
    lo = 1'b0;
    bz = 1'b0;
    cp_abs <= ab;
    cp_slow <= sl;
    core_req_in.cp_valid <= 1'b1;
    @(posedge core_clk_in);
    core_req_in.cp_valid <= 1'b0;
    do begin
      @(negedge core_clk_in);
      n++;
      if (!coproc_instr_n_out) lo = 1'b1;
      if (core_rsp_out.cp_busy) bz = 1'b1;
    end while (!(core_rsp_out.cp_done | core_rsp_out.cp_undef) && n < 300);
    chk("select low", {31'h0, lo}, 32'h1);
    chk("cp busy", {31'h0, bz}, 32'h1);
    chk("undefined trap", {31'h0, core_rsp_out.cp_undef}, {31'h0, ab});
    chk("cp done", {31'h0, core_rsp_out.cp_done}, {31'h0, !ab});
    if (sl) chk("busy wait", {31'h0, n >= 24}, 32'h1);
    @(posedge core_clk_in);
  endtask

  initial begin
    repeat (20) @(posedge core_clk_in);
    srst_in <= 1'b0;
    settle(8);
    foreach (rows[i]) begin
      // width changes only while no transfer is pending
      wide_data_space_sel_in <= rows[i].wide;
      slow <= rows[i].slow;
      rd_word <= rows[i].d;
      settle(8);
      xfer(rows[i].w, rows[i].a, rows[i].d);
      chk("address", ad, rows[i].a & (rows[i].wide ? 32'hFFFFFFFF : NARROW_ADDR_MASK));
      if (rows[i].w) chk("write word", wd, rows[i].d);
      else chk("read word", rd, rows[i].d);
      chk("drive on write", {31'h0, oe}, {31'h0, rows[i].w});
      chk("write flag", {31'h0, rw}, {31'h0, rows[i].w});
    end
    core_data_bus_en_in <= 1'b0;
    settle(6);
    xfer(1'b1, 32'h00000020, 32'h55AA55AA);
    chk("bus floated", {31'h0, oe}, 32'h0);
    core_data_bus_en_in <= 1'b1;
    cp(1'b1, 1'b0);
    cp(1'b0, 1'b0);
    cp(1'b0, 1'b1);
    debug_enable_in <= 1'b1;
    debug_request_in <= 1'b1;
    ext_cond_0_in <= 1'b1;
    debug_clock_in <= 1'b1;
    settle(6);
    core_req_in.instr_done <= 1'b1;
    @(posedge core_clk_in);
    core_req_in.instr_done <= 1'b0;
    settle(6);
    chk("debug ack", {31'h0, debug_ack_out}, 32'h1);
    chk("halt request", {31'h0, core_rsp_out.halt_req}, 32'h1);
    chk("debug clock", {31'h0, exported_clock_out}, 32'h1);
    chk("ext conditions", {30'h0, ext_cond_out}, 32'h1);
    debug_clock_in <= 1'b0;
    ext_cond_0_in <= 1'b0;
    ext_cond_1_in <= 1'b1;
    settle(6);
    chk("debug clock low", {31'h0, exported_clock_out}, 32'h0);
    chk("ext conditions", {30'h0, ext_cond_out}, 32'h2);
    core_req_in.debug_exit <= 1'b1;
    @(posedge core_clk_in);
    core_req_in.debug_exit <= 1'b0;
    debug_enable_in <= 1'b0;
    settle(6);
    core_req_in.instr_done <= 1'b1;
    @(posedge core_clk_in);
    core_req_in.instr_done <= 1'b0;
    settle(6);
    chk("ack disabled", {31'h0, debug_ack_out}, 32'h0);
    chk("ext disabled", {30'h0, ext_cond_out}, 32'h0);
    tap_float_outputs_flag_loaded_in <= 1'b1;
    core_req_in.swap <= 1'b1;
    settle(12);
    chk("float flag", {31'h0, float_outputs_flag_out}, 32'h1);
    chk("lock", {31'h0, lock_out}, 32'h1);
    chk("lock driven", {31'h0, lock_oe_out}, 32'h1);
    chk("rw driven", {31'h0, write_not_read_oe_out}, 32'h1);
    addr_drive_en_in <= 1'b0;
    addr_latch_en_in <= 1'b0;
    tap_float_outputs_flag_loaded_in <= 1'b0;
    settle(6);
    chk("lock floated", {31'h0, lock_oe_out}, 32'h0);
    chk("rw floated", {31'h0, write_not_read_oe_out}, 32'h0);
    addr_drive_en_in <= 1'b1;
    core_req_in.swap <= 1'b0;
    settle(12);
    // latch closed: the lock level must hold although the swap has ended
    chk("lock held", {31'h0, lock_out}, 32'h1);
    addr_latch_en_in <= 1'b1;
    settle(12);
    chk("lock released", {31'h0, lock_out}, 32'h0);
    for (int s = 1; s >= 0; s--) begin
      irq_already_sync_in <= s[0];
      irq_req_n_in <= 1'b1;
      fast_irq_req_n_in <= 1'b1;
      settle(6);
      irq_req_n_in <= 1'b0;
      fast_irq_req_n_in <= 1'b0;
      repeat (3) @(negedge core_clk_in);
      chk("irq latency", {30'h0, irq_req_n_out, fast_irq_req_n_out}, {30'h0, !s[0], !s[0]});
      @(posedge core_clk_in);
    end
    srst_in <= 1'b1;
    settle(3);
    chk("reset outputs", {25'h0, coproc_instr_n_out, irq_req_n_out, fast_irq_req_n_out,
      data_oe_out, debug_ack_out, lock_out, core_rsp_out.xfer_busy}, 32'h70);
    end_sim();
  end
endmodule // pic_top_test
`default_nettype wire
